// ### rtl/slptc_config.sv
// Lane polarity and transmit tap configuration registers with data-path inversion.
// Assumes requests arrive already decoded from the management serial interface,
// synchronous to clk, and that lane data words are on the same clock.
`timescale 1ns/10ps
module slptc_config #(
   parameter int LANE_W = 20
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire slptc_pkg::slptc_req_t req,
   output logic                       rd_valid,
   output logic [15:0]                rd_data,
   input  wire logic [LANE_W-1:0]     rx_lane_in,
   output logic [LANE_W-1:0]          rx_lane_out,
   input  wire logic [LANE_W-1:0]     tx_lane_in,
   output logic [LANE_W-1:0]          tx_lane_out,
   output logic                       rx_polarity_swap,
   output logic                       tx_polarity_swap,
   output slptc_pkg::slptc_taps_t     tap_code,
   output slptc_pkg::slptc_steps_t    tap_steps,
   output logic [15:0]                ls_lane_control_one
);

   logic [15:0]         hs_ff,    nxt_hs;
   logic [15:0]         ls_ff,    nxt_ls;
   logic                rdv_ff,   nxt_rdv;
   logic [15:0]         rdd_ff,   nxt_rdd;
   logic [LANE_W-1:0]   rxo_ff,   nxt_rxo;
   logic [LANE_W-1:0]   txo_ff,   nxt_txo;
   logic                sel_dev;
   logic                hit_hs;
   logic                hit_ls;

   // Converts a sign-magnitude code to two's complement steps.
   function automatic logic signed [5:0] sm_to_steps(input logic sgn,
                                                     input logic [3:0] mag);
      logic signed [5:0] v;
      v = $signed({2'h0, mag});
      sm_to_steps = (sgn && (mag != 4'h0)) ? -v : v;
   endfunction : sm_to_steps

   assign sel_dev = (req.dev == slptc_pkg::DEV_ADDR);
   assign hit_hs  = sel_dev && (req.addr == slptc_pkg::HS_TAPS_ADDR);
   assign hit_ls  = sel_dev && (req.addr == slptc_pkg::LS_CTRL1_ADDR);

   always_comb begin
      nxt_hs  = hs_ff;
      nxt_ls  = ls_ff;
      nxt_rdv = 1'b0;
      nxt_rdd = rdd_ff;
      // All sixteen bits are plain storage, reserved bit 13 included.
      if (req.wr && hit_hs) begin
         nxt_hs = req.wdata;
      end
      if (req.wr && hit_ls) begin
         nxt_ls = req.wdata;
      end
      if (req.rd) begin
         nxt_rdv = 1'b1;
         // Unmapped addresses read as zero so a stray read is harmless.
         nxt_rdd = hit_hs ? hs_ff : (hit_ls ? ls_ff : 16'h0000);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hs_ff  <= slptc_pkg::HS_TAPS_RESET;
         ls_ff  <= slptc_pkg::LS_CTRL1_RESET;
         rdv_ff <= 1'b0;
         rdd_ff <= 16'h0000;
      end else begin
         hs_ff  <= nxt_hs;
         ls_ff  <= nxt_ls;
         rdv_ff <= nxt_rdv;
         rdd_ff <= nxt_rdd;
      end
   end

   // The data path uses the stored bits, so the new polarity is in force on
   // the first data word registered after the write edge.
   always_comb begin
      nxt_rxo = hs_ff[slptc_pkg::RX_SWAP_BIT] ? ~rx_lane_in : rx_lane_in;
      nxt_txo = hs_ff[slptc_pkg::TX_SWAP_BIT] ? ~tx_lane_in : tx_lane_in;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rxo_ff <= '0;
         txo_ff <= '0;
      end else begin
         rxo_ff <= nxt_rxo;
         txo_ff <= nxt_txo;
      end
   end

   assign rd_valid            = rdv_ff;
   assign rd_data             = rdd_ff;
   assign rx_lane_out         = rxo_ff;
   assign tx_lane_out         = txo_ff;
   assign rx_polarity_swap    = hs_ff[slptc_pkg::RX_SWAP_BIT];
   assign tx_polarity_swap    = hs_ff[slptc_pkg::TX_SWAP_BIT];
   assign ls_lane_control_one = ls_ff;
   assign tap_code.post1 = hs_ff[slptc_pkg::POST1_MSB:slptc_pkg::POST1_LSB];
   assign tap_code.pre   = hs_ff[slptc_pkg::PRE_MSB:slptc_pkg::PRE_LSB];
   assign tap_code.post2 = hs_ff[slptc_pkg::POST2_MSB:slptc_pkg::POST2_LSB];
   // Each magnitude tops out at its field width: 15 steps for the first
   // post tap, 7 for the other two; negative zero collapses to zero.
   assign tap_steps.post1 = sm_to_steps(tap_code.post1[4], tap_code.post1[3:0]);
   assign tap_steps.pre   = 5'(sm_to_steps(tap_code.pre[3], {1'b0, tap_code.pre[2:0]}));
   assign tap_steps.post2 = 5'(sm_to_steps(tap_code.post2[3],
                                           {1'b0, tap_code.post2[2:0]}));

   // Requests are decoded here straight from the package constants, apart from
   // the decode above, so that a broken address compare cannot hide itself.
   sequence s_hs_wr;
      req.wr && (req.dev == slptc_pkg::DEV_ADDR) && (req.addr == slptc_pkg::HS_TAPS_ADDR);
   endsequence

   sequence s_ls_wr;
      req.wr && (req.dev == slptc_pkg::DEV_ADDR) && (req.addr == slptc_pkg::LS_CTRL1_ADDR);
   endsequence

   // A lone read; a read beside a write is left to the write checks.
   sequence s_hs_rd;
      req.rd && !req.wr && (req.dev == slptc_pkg::DEV_ADDR)
         && (req.addr == slptc_pkg::HS_TAPS_ADDR);
   endsequence

   sequence s_ls_rd;
      req.rd && !req.wr && (req.dev == slptc_pkg::DEV_ADDR)
         && (req.addr == slptc_pkg::LS_CTRL1_ADDR);
   endsequence

   // A write that turns on a lane inversion.
   sequence s_rx_swap_on;
      s_hs_wr ##0 req.wdata[slptc_pkg::RX_SWAP_BIT];
   endsequence

   sequence s_tx_swap_on;
      s_hs_wr ##0 req.wdata[slptc_pkg::TX_SWAP_BIT];
   endsequence

   AST_HS_RESET: assert property (@(posedge clk)
      !rst_n |=> hs_ff == slptc_pkg::HS_TAPS_RESET)
      else $error("control four reset value wrong");
   AST_LS_RESET: assert property (@(posedge clk)
      !rst_n |=> ls_ff == slptc_pkg::LS_CTRL1_RESET)
      else $error("low-speed control one reset value wrong");
   AST_HS_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      s_hs_wr |=> hs_ff == $past(req.wdata))
      else $error("control four write not stored");
   AST_HS_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !(req.wr && (req.dev == slptc_pkg::DEV_ADDR) && (req.addr == slptc_pkg::HS_TAPS_ADDR))
      |=> $stable(hs_ff))
      else $error("control four changed without a write to it");
   AST_HS_READ: assert property (@(posedge clk) disable iff (!rst_n)
      s_hs_rd |=> rd_valid && (rd_data == $past(hs_ff)))
      else $error("control four read returned wrong data");
   AST_LS_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      s_ls_wr |=> ls_lane_control_one == $past(req.wdata))
      else $error("low-speed control one write not stored");
   AST_LS_READ: assert property (@(posedge clk) disable iff (!rst_n)
      s_ls_rd |=> rd_valid && (rd_data == $past(ls_ff)))
      else $error("low-speed control one read returned wrong data");
   AST_RD_STROBE: assert property (@(posedge clk) disable iff (!rst_n)
      !req.rd |=> !rd_valid)
      else $error("read answer strobe without a read");
   AST_RX_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
      s_hs_wr |=> rx_polarity_swap == $past(req.wdata[slptc_pkg::RX_SWAP_BIT]))
      else $error("receive swap flag not taken from write");
   AST_TX_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
      s_hs_wr |=> tx_polarity_swap == $past(req.wdata[slptc_pkg::TX_SWAP_BIT]))
      else $error("transmit swap flag not taken from write");
   AST_RX_SWAP: assert property (@(posedge clk) disable iff (!rst_n)
      rx_polarity_swap |=> rx_lane_out == ~$past(rx_lane_in))
      else $error("receive lane not inverted");
   AST_RX_NORM: assert property (@(posedge clk) disable iff (!rst_n)
      !rx_polarity_swap |=> rx_lane_out == $past(rx_lane_in))
      else $error("receive lane altered without swap");
   AST_TX_SWAP: assert property (@(posedge clk) disable iff (!rst_n)
      tx_polarity_swap |=> tx_lane_out == ~$past(tx_lane_in))
      else $error("transmit lane not inverted");
   AST_TX_NORM: assert property (@(posedge clk) disable iff (!rst_n)
      !tx_polarity_swap |=> tx_lane_out == $past(tx_lane_in))
      else $error("transmit lane altered without swap");
   AST_RSVD_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      s_hs_wr |=> hs_ff[slptc_pkg::RSVD_BIT] == $past(req.wdata[slptc_pkg::RSVD_BIT]))
      else $error("reserved bit not stored");
   AST_TAP_CODE: assert property (@(posedge clk) disable iff (!rst_n)
      s_hs_wr |=> tap_code == $past(req.wdata[slptc_pkg::POST1_MSB:slptc_pkg::POST2_LSB]))
      else $error("tap codes not taken from write");
   AST_POST1_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      tap_code.post1[3:0] == 4'h0 |-> tap_steps.post1 == 6'sh00)
      else $error("zero magnitude first post tap not zero");
   AST_POST1_NEG: assert property (@(posedge clk) disable iff (!rst_n)
      tap_code.post1[4] |-> tap_steps.post1 == -$signed({2'h0, tap_code.post1[3:0]}))
      else $error("first post tap negative value wrong");
   AST_POST1_POS: assert property (@(posedge clk) disable iff (!rst_n)
      !tap_code.post1[4] |-> tap_steps.post1 == $signed({2'h0, tap_code.post1[3:0]}))
      else $error("first post tap positive value wrong");
   AST_PRE_NEG: assert property (@(posedge clk) disable iff (!rst_n)
      tap_code.pre[3] |-> tap_steps.pre == -$signed({2'h0, tap_code.pre[2:0]}))
      else $error("pre tap sign wrong");
   AST_PRE_POS: assert property (@(posedge clk) disable iff (!rst_n)
      !tap_code.pre[3] |-> tap_steps.pre == $signed({2'h0, tap_code.pre[2:0]}))
      else $error("pre tap positive value wrong");
   AST_POST2_POS: assert property (@(posedge clk) disable iff (!rst_n)
      !tap_code.post2[3] |-> tap_steps.post2 == $signed({2'h0, tap_code.post2[2:0]}))
      else $error("second post tap value wrong");
   AST_POST2_NEG: assert property (@(posedge clk) disable iff (!rst_n)
      tap_code.post2[3] |-> tap_steps.post2 == -$signed({2'h0, tap_code.post2[2:0]}))
      else $error("second post tap negative value wrong");
   AST_SWAP_TIMING: assert property (@(posedge clk) disable iff (!rst_n)
      s_rx_swap_on |=> ##1 rx_lane_out == ~$past(rx_lane_in))
      else $error("receive inversion late after write");
   AST_TX_SWAP_TIMING: assert property (@(posedge clk) disable iff (!rst_n)
      s_tx_swap_on |=> ##1 tx_lane_out == ~$past(tx_lane_in))
      else $error("transmit inversion late after write");

endmodule : slptc_config

// ### common/slptc_pkg.sv
// Package for the lane polarity and transmit tap configuration slice.
// Assumes a management-register access port of 5-bit device address,
// 16-bit register address and 16-bit data, as used by the device's
// management serial interface.
package slptc_pkg;

   localparam logic [4:0]  DEV_ADDR        = 5'h1E;
   localparam logic [15:0] HS_TAPS_ADDR    = 16'h0005;
   localparam logic [15:0] HS_TAPS_RESET   = 16'h2000;
   localparam logic [15:0] LS_CTRL1_ADDR   = 16'h0006;
   localparam logic [15:0] LS_CTRL1_RESET  = 16'hF115;

   localparam int RX_SWAP_BIT  = 15;
   localparam int TX_SWAP_BIT  = 14;
   localparam int RSVD_BIT     = 13;
   localparam int POST1_MSB    = 12;
   localparam int POST1_LSB    = 8;
   localparam int PRE_MSB      = 7;
   localparam int PRE_LSB      = 4;
   localparam int POST2_MSB    = 3;
   localparam int POST2_LSB    = 0;

   // Register write or read request from the management serial interface.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  dev;
      logic [15:0] addr;
      logic [15:0] wdata;
   } slptc_req_t;

   // Tap weights in sign-magnitude form, sign in the top bit.
   typedef struct packed {
      logic [4:0] post1;
      logic [3:0] pre;
      logic [3:0] post2;
   } slptc_taps_t;

   // Signed weight in 2.5 percent steps; zero magnitude gives zero.
   typedef struct packed {
      logic signed [5:0] post1;
      logic signed [4:0] pre;
      logic signed [4:0] post2;
   } slptc_steps_t;

endpackage : slptc_pkg

// ### verif/slptc_config_bench.sv
// Self-checking bench for the lane polarity and transmit tap configuration slice.
// Assumes the design holds its own assertions; the bench drives every input at falling edges.
`timescale 1ns/10ps
module serdes_lane_polarity_tap_config_bench;
   logic                    clk      = 1'b0;
   logic                    rst_n    = 1'b0;
   slptc_pkg::slptc_req_t   req      = '0;
   logic [19:0]             rx_in    = 20'hA5C3F;
   logic [19:0]             tx_in    = 20'h3C5A1;
   logic                    rd_valid;
   logic [15:0]             rd_data;
   logic [19:0]             rx_out;
   logic [19:0]             tx_out;
   logic                    rx_sw;
   logic                    tx_sw;
   slptc_pkg::slptc_taps_t  taps;
   slptc_pkg::slptc_steps_t steps;
   logic [15:0]             ls1;
   int                      n_fail   = 0;
   int                      compares = 0;
   localparam logic [4:0]   DV = slptc_pkg::DEV_ADDR;
   always #2 clk = ~clk;
   slptc_config #(.LANE_W(20)) i_slptc_config (.clk(clk), .rst_n(rst_n), .req(req),
      .rd_valid(rd_valid), .rd_data(rd_data), .rx_lane_in(rx_in), .rx_lane_out(rx_out),
      .tx_lane_in(tx_in), .tx_lane_out(tx_out), .rx_polarity_swap(rx_sw),
      .tx_polarity_swap(tx_sw), .tap_code(taps), .tap_steps(steps), .ls_lane_control_one(ls1));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   // An idle cycle ends each access, so back-to-back calls never drive req twice at once.
   task automatic wr(input logic [4:0] dv, input logic [15:0] a, input logic [15:0] d);
      req = '{1'b1, 1'b0, dv, a, d};
      @(negedge clk);
      req = '0;
      @(negedge clk);
   endtask : wr
   // The answer strobe is due one cycle after the request and lasts just that cycle.
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      req = '{1'b0, 1'b1, DV, a, 16'h0000};
      @(negedge clk);
      req = '0;
      chk({31'h0, rd_valid}, 32'h1);
      chk({16'h0, rd_data}, {16'h0, exp});
      @(negedge clk);
      chk({31'h0, rd_valid}, 32'h0);
   endtask : rd
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      rd(slptc_pkg::HS_TAPS_ADDR, slptc_pkg::HS_TAPS_RESET);
      rd(slptc_pkg::LS_CTRL1_ADDR, slptc_pkg::LS_CTRL1_RESET);
      chk({16'h0, ls1}, {16'h0, slptc_pkg::LS_CTRL1_RESET});
      chk({12'h0, rx_out}, {12'h0, rx_in});
      chk({12'h0, tx_out}, {12'h0, tx_in});
      $display("Test reset values done");
      wr(DV, 16'h0005, 16'h8000);
      chk({31'h0, rx_sw}, 32'h1);
      rx_in = 20'h5A3C0;
      @(negedge clk);
      chk({12'h0, rx_out}, {12'h0, ~rx_in});
      chk({12'h0, tx_out}, {12'h0, tx_in});
      wr(DV, 16'h0005, 16'h4000);
      tx_in = 20'hC3A5E;
      @(negedge clk);
      chk({12'h0, rx_out}, {12'h0, rx_in});
      chk({12'h0, tx_out}, {12'h0, ~tx_in});
      chk({30'h0, tx_sw, rx_sw}, 32'h2);
      $display("Test polarity done");
      wr(DV, 16'h0005, 16'h1FFF);
      chk({19'h0, taps}, 32'h1FFF);
      chk({16'h0, steps}, 32'hC739);
      rd(16'h0005, 16'h1FFF);
      wr(DV, 16'h0005, 16'h0F77);
      chk({16'h0, steps}, 32'h3CE7);
      wr(DV, 16'h0005, 16'h1088);
      chk({16'h0, steps}, 32'h0000);
      $display("Test tap weights done");
      wr(5'h1F, 16'h0005, 16'hFFFF);
      rd(16'h0005, 16'h1088);
      wr(DV, 16'h0007, 16'hFFFF);
      rd(16'h0007, 16'h0000);
      wr(DV, 16'h0006, 16'h1234);
      rd(16'h0006, 16'h1234);
      chk({16'h0, ls1}, 32'h1234);
      $display("Test decode done");
      wr(DV, 16'h0005, 16'hE000);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk({30'h0, tx_sw, rx_sw}, 32'h0);
      chk({16'h0, ls1}, {16'h0, slptc_pkg::LS_CTRL1_RESET});
      rd(slptc_pkg::HS_TAPS_ADDR, slptc_pkg::HS_TAPS_RESET);
      $display("Test reset in mid-run done");
      complete_run();
   end
   // The tests need under 100 cycles; this margin only catches a hang.
   initial begin
      #4000;
      n_fail++;
      complete_run();
   end
endmodule : serdes_lane_polarity_tap_config_bench
